// >>> shared/simc_map.svh
`ifndef SIMC_MAP_SVH
`define SIMC_MAP_SVH
// bit positions inside the interface mode register
`define SIMC_BIT_REG_CRC_EN   13
`define SIMC_BIT_RX_CRC_EN    12
`define SIMC_BIT_CRC_TYPE     11
`define SIMC_BIT_RESET_FLAG   10
`define SIMC_WS_HI            9
`define SIMC_WS_LO            8
`define SIMC_RSVD_HI          7
`define SIMC_RSVD_LO          5
`define SIMC_BIT_TIMEOUT_EN   4
`define SIMC_SEL_HI           3
`define SIMC_SEL_LO           0
// reset value: reset flag, 24-bit words, timeout on
`define SIMC_MODE_RESET       16'h0510
// writable bits; 15:14 read as zero, 7:5 held at zero
`define SIMC_MODE_WMASK       16'h3F1F
`define SIMC_WS_16            2'h0
`define SIMC_WS_24            2'h1
`define SIMC_WS_32_PAD        2'h2
`define SIMC_WS_32_SEXT       2'h3
`define SIMC_LEN_16           6'h10
`define SIMC_LEN_24           6'h18
`define SIMC_LEN_32           6'h20
`define SIMC_TOP_HI           15
`define SIMC_TOP_LO           14
`define SIMC_WORD_RESET       32'h0000_0000
// sample and formatted word slices
`define SIMC_SMP_MSB          23
`define SIMC_SMP16_LO         8
`define SIMC_EXT_HI           31
`define SIMC_EXT_LO           24
`define SIMC_PAD_HI           7
`define SIMC_PAD_LO           0
`endif

// >>> shared/simc_pkg.sv
package simc_pkg;
	typedef enum logic [1:0] {
		SIMC_WS16      = 2'h0,
		SIMC_WS24      = 2'h1,
		SIMC_WS32_PAD  = 2'h2,
		SIMC_WS32_SEXT = 2'h3
	} simc_word_size_type;
	typedef logic [15:0] simc_reg_type;
	typedef logic [31:0] simc_word_type;
endpackage : simc_pkg

// >>> rtl/simc_word_format.sv
`timescale 1ns/10ps
`include "simc_map.svh"
module simc_word_format (
	// selection
	input  wire simc_pkg::simc_word_size_type word_size_select,
	// 24-bit conversion result
	input  wire logic [23:0]                  sample,
	// formatted word, left aligned in 32 bits except in sign-extend mode, where the sample sits in bits 23:0
	output logic [31:0]                       word,
	output logic [5:0]                        word_bits
);
	import simc_pkg::*;
	always_comb begin
		unique case (word_size_select)
			SIMC_WS16: begin
				word      = {sample[`SIMC_SMP_MSB:`SIMC_SMP16_LO], 16'h0000};
				word_bits = `SIMC_LEN_16;
			end
			SIMC_WS24: begin
				word      = {sample, 8'h00};
				word_bits = `SIMC_LEN_24;
			end
			SIMC_WS32_PAD: begin
				word      = {sample, 8'h00};
				word_bits = `SIMC_LEN_32;
			end
			SIMC_WS32_SEXT: begin
				word      = {{8{sample[`SIMC_SMP_MSB]}}, sample};
				word_bits = `SIMC_LEN_32;
			end
		endcase
	end
endmodule : simc_word_format

// >>> rtl/simc_mode_reg.sv
`timescale 1ns/10ps
`include "simc_map.svh"
// Notes on behaviour
// - bit 12 enables incoming frame CRC check
// - bit 11 picks CCITT or ANSI polynomial
// - bit 10 set by reset, host clears
// - bits 9:8 select 16 or 24 bits
// - 10b zero-pads, 11b sign-extends 32 bits
// - bit 4 enables timeout, resets on
module simc_mode_reg (
	// clock and reset
	input  wire logic                         clk,
	input  wire logic                         reset,
	// register access from the serial command decoder
	input  wire logic                         wr_en,
	input  wire simc_pkg::simc_reg_type       wr_data,
	output simc_pkg::simc_reg_type            rd_data,
	// sample to format
	input  wire logic [23:0]                  sample,
	output simc_pkg::simc_word_type           out_word,
	output logic [5:0]                        out_word_bits,
	// controls to the rest of the device
	output logic                              rx_crc_check_en,
	output logic                              reg_crc_en,
	output logic                              crc_poly_ansi,
	output logic                              reset_seen,
	output logic                              timeout_en,
	output simc_pkg::simc_word_size_type      word_size_select
);
	import simc_pkg::*;

	simc_reg_type  mode_r;
	simc_reg_type  mode_nxt;
	simc_word_type fmt_word;
	logic [5:0]    fmt_bits;
	simc_word_type word_r;
	simc_word_type word_nxt;
	logic [5:0]    bits_r;
	logic [5:0]    bits_nxt;

	// host write; the flag has no hardware set besides reset, so a
	// clearing write can never race a set in the same cycle
	always_comb begin
		mode_nxt = mode_r;
		if (wr_en) begin
			// reserved bits keep zero whatever the host writes
			mode_nxt = wr_data & `SIMC_MODE_WMASK;
		end
	end

	// reset raises the flag, selects 24-bit words and arms the timeout
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode_r <= `SIMC_MODE_RESET;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// formatter follows the field as it stands in this cycle
	simc_word_format u_fmt (
		.word_size_select (word_size_select),
		.sample           (sample),
		.word             (fmt_word),
		.word_bits        (fmt_bits)
	);

	always_comb begin
		word_nxt = fmt_word;
		bits_nxt = fmt_bits;
	end

	// registered every cycle, so a field change reaches out_word and out_word_bits one cycle later
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			word_r <= `SIMC_WORD_RESET;
			bits_r <= `SIMC_LEN_24;
		end else begin
			word_r <= word_nxt;
			bits_r <= bits_nxt;
		end
	end

	// every control is a plain register bit, so it changes only on a write or on reset
	assign rd_data          = mode_r;
	assign rx_crc_check_en  = mode_r[`SIMC_BIT_RX_CRC_EN];
	assign reg_crc_en       = mode_r[`SIMC_BIT_REG_CRC_EN];
	assign crc_poly_ansi    = mode_r[`SIMC_BIT_CRC_TYPE];
	assign reset_seen       = mode_r[`SIMC_BIT_RESET_FLAG];
	assign timeout_en       = mode_r[`SIMC_BIT_TIMEOUT_EN];
	assign word_size_select = simc_word_size_type'(mode_r[`SIMC_WS_HI:`SIMC_WS_LO]);
	assign out_word         = word_r;
	assign out_word_bits    = bits_r;

	// incoming frame crc check enable; a write on an edge still in reset is not taken
	crc_chk_a: assert property (
		@(posedge clk) disable iff (reset)
		!reset && wr_en |=> rx_crc_check_en == $past(wr_data[`SIMC_BIT_RX_CRC_EN]))
		else $error("crc check enable wrong");

	crc_hold_a: assert property (
		@(posedge clk) disable iff (reset)
		!wr_en |=> $stable(rx_crc_check_en))
		else $error("crc check enable changed without write");

	write_takes_a: assert property (
		@(posedge clk) disable iff (reset)
		!reset && wr_en |=> rd_data == ($past(wr_data) & `SIMC_MODE_WMASK))
		else $error("mode write lost");

	// polynomial select and register map crc enable
	poly_sel_a: assert property (
		@(posedge clk) disable iff (reset)
		!reset && wr_en ##1 1'b1 |-> crc_poly_ansi == $past(wr_data[`SIMC_BIT_CRC_TYPE]))
		else $error("poly select wrong");

	poly_hold_a: assert property (
		@(posedge clk) disable iff (reset)
		!wr_en |=> $stable(crc_poly_ansi))
		else $error("poly select changed without write");

	map_crc_a: assert property (
		@(posedge clk) disable iff (reset)
		!reset && wr_en |=> reg_crc_en == $past(wr_data[`SIMC_BIT_REG_CRC_EN]))
		else $error("register crc enable wrong");

	// reset flag: raised by reset, cleared by a host write of zero
	flag_clear_a: assert property (
		@(posedge clk) disable iff (reset)
		!reset && wr_en && !wr_data[`SIMC_BIT_RESET_FLAG] |=> !reset_seen)
		else $error("reset flag not cleared");

	flag_set_a: assert property (
		@(posedge clk) disable iff (reset)
		!reset && wr_en && wr_data[`SIMC_BIT_RESET_FLAG] |=> reset_seen)
		else $error("reset flag write of one lost");

	flag_hold_a: assert property (
		@(posedge clk) disable iff (reset)
		!wr_en |=> $stable(reset_seen))
		else $error("reset flag changed without write");

	hold_value_a: assert property (
		@(posedge clk) disable iff (reset)
		!wr_en |=> $stable(rd_data))
		else $error("mode changed without write");

	reset_load_a: assert property (
		@(posedge clk) disable iff (reset)
		$fell(reset) |-> rd_data == `SIMC_MODE_RESET)
		else $error("mode reset value wrong");

	// word length select and the 16 and 24-bit formats
	ws_take_a: assert property (
		@(posedge clk) disable iff (reset)
		!reset && wr_en |=> word_size_select == $past(wr_data[`SIMC_WS_HI:`SIMC_WS_LO]))
		else $error("word size write lost");

	ws_hold_a: assert property (
		@(posedge clk) disable iff (reset)
		!wr_en |=> $stable(word_size_select))
		else $error("word size changed without write");

	word_rst_a: assert property (
		@(posedge clk) disable iff (reset)
		$fell(reset) |-> out_word == `SIMC_WORD_RESET && out_word_bits == `SIMC_LEN_24)
		else $error("word reset value wrong");

	len16_a: assert property (
		@(posedge clk) disable iff (reset)
		!reset && word_size_select == SIMC_WS16 |=> out_word_bits == `SIMC_LEN_16)
		else $error("16-bit length wrong");

	w16_data_a: assert property (
		@(posedge clk) disable iff (reset)
		!reset && word_size_select == SIMC_WS16 |=> out_word == {$past(sample[`SIMC_SMP_MSB:`SIMC_SMP16_LO]), 16'h0000})
		else $error("16-bit word wrong");

	len24_a: assert property (
		@(posedge clk) disable iff (reset)
		!reset && word_size_select == SIMC_WS24 |=> out_word_bits == `SIMC_LEN_24)
		else $error("24-bit length wrong");

	w24_data_a: assert property (
		@(posedge clk) disable iff (reset)
		!reset && word_size_select == SIMC_WS24 |=> out_word == {$past(sample), 8'h00})
		else $error("24-bit word wrong");

	// 32-bit formats
	pad_word_a: assert property (
		@(posedge clk) disable iff (reset)
		!reset && word_size_select == SIMC_WS32_PAD |=> out_word[`SIMC_PAD_HI:`SIMC_PAD_LO] == 8'h00 && out_word_bits == `SIMC_LEN_32)
		else $error("zero pad wrong");

	pad_data_a: assert property (
		@(posedge clk) disable iff (reset)
		!reset && word_size_select == SIMC_WS32_PAD |=> out_word == {$past(sample), 8'h00})
		else $error("padded word wrong");

	sext_word_a: assert property (
		@(posedge clk) disable iff (reset)
		!reset && word_size_select == SIMC_WS32_SEXT |=> out_word[`SIMC_EXT_HI:`SIMC_EXT_LO] == {8{$past(sample[`SIMC_SMP_MSB])}})
		else $error("sign ext");

	sext_data_a: assert property (
		@(posedge clk) disable iff (reset)
		!reset && word_size_select == SIMC_WS32_SEXT |=> out_word[`SIMC_SMP_MSB:`SIMC_PAD_LO] == $past(sample))
		else $error("sign extended word wrong");

	// reserved bits
	rsvd_zero_a: assert property (
		@(posedge clk) disable iff (reset)
		rd_data[`SIMC_RSVD_HI:`SIMC_RSVD_LO] == 3'h0 && rd_data[`SIMC_TOP_HI:`SIMC_TOP_LO] == 2'h0)
		else $error("reserved bits set");

	// serial timeout enable
	timeout_off_a: assert property (
		@(posedge clk) disable iff (reset)
		!reset && wr_en && !wr_data[`SIMC_BIT_TIMEOUT_EN] |=> !timeout_en)
		else $error("timeout not disabled");

	timeout_on_a: assert property (
		@(posedge clk) disable iff (reset)
		!reset && wr_en && wr_data[`SIMC_BIT_TIMEOUT_EN] |=> timeout_en)
		else $error("timeout not enabled");

	timeout_hold_a: assert property (
		@(posedge clk) disable iff (reset)
		!wr_en |=> $stable(timeout_en))
		else $error("timeout enable changed without write");
endmodule : simc_mode_reg

// >>> testbench/simc_host_model.sv
`timescale 1ns/10ps
module simc_host_model (
	// bus
	input  wire logic              clk,
	output logic                   wr_en,
	output simc_pkg::simc_reg_type wr_data
);
	import simc_pkg::*;
	initial begin
		wr_en = 1'b0;
		wr_data = 16'h0000;
	end
	// released data is inverted so a stale value cannot pass
	task automatic put(input simc_reg_type v);
		@(posedge clk);
		wr_en <= 1'b1;
		wr_data <= v & 16'hFF1F;
		@(posedge clk);
		wr_en <= 1'b0;
		wr_data <= ~(v & 16'hFF1F);
	endtask : put
endmodule : simc_host_model

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import simc_pkg::*;
	logic               clk, reset, wr_en, rx, rc, pa, rs, to;
	logic [23:0]        sample;
	logic [5:0]         bits;
	simc_reg_type       wr_data, rd_data;
	simc_word_type      ow;
	simc_word_size_type ws;
	int                 error_cnt = 0;
	int                 checked = 0;
	logic [31:0]        ew [4] = '{32'h80120000, 32'h80123400, 32'h80123400, 32'hFF801234};
	logic [5:0]         eb [4] = '{6'h10, 6'h18, 6'h20, 6'h20};
	simc_host_model i_host (.clk(clk), .wr_en(wr_en), .wr_data(wr_data));
	simc_mode_reg i_dut (.clk(clk), .reset(reset), .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data),
		.sample(sample), .out_word(ow), .out_word_bits(bits), .rx_crc_check_en(rx), .reg_crc_en(rc),
		.crc_poly_ansi(pa), .reset_seen(rs), .timeout_en(to), .word_size_select(ws));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	task automatic t_reset;
		chk("rd_data", 32'h0510, rd_data);
		chk("reset_seen", 32'h1, rs);
		chk("timeout_en", 32'h1, to);
		chk("rx_crc", 32'h0, rx);
		chk("poly", 32'h0, pa);
		chk("reg_crc", 32'h0, rc);
		chk("word_size", 32'h1, ws);
		chk("word_bits", 32'h18, bits);
		chk("out_word", 32'h0, ow);
		$display("reset values done");
	endtask : t_reset
	task automatic t_fields;
		i_host.put(16'hFFFF);
		#1 chk("rd_data", 32'h3F1F, rd_data);
		chk("rx_crc", 32'h1, rx);
		chk("poly", 32'h1, pa);
		chk("reg_crc", 32'h1, rc);
		chk("reset_seen", 32'h1, rs);
		chk("word_size", 32'h3, ws);
		i_host.put(16'h0000);
		#1 chk("reset_seen", 32'h0, rs);
		chk("timeout_en", 32'h0, to);
		chk("rd_data", 32'h0, rd_data);
		chk("reg_crc", 32'h0, rc);
		// two edges in reset so no check straddles the release
		@(posedge clk) reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		#1 t_reset();
		$display("field writes done");
	endtask : t_fields
	task automatic t_format;
		@(posedge clk) sample <= 24'h801234;
		for (int i = 0; i < 4; i++) begin
			i_host.put({6'h00, i[1:0], 8'h10});
			@(posedge clk);
			#1 chk("out_word", ew[i], ow);
			chk("word_bits", eb[i], bits);
		end
		$display("word formats done");
	endtask : t_format
	initial begin
		reset = 1'b1;
		sample = 24'h000000;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		#1 t_reset();
		t_fields();
		t_format();
		end_sim();
	end
	initial begin
		#20000;
		error_cnt++;
		end_sim();
	end
endmodule : tb_top
